// ---- inc/cbseq_pkg.sv ----
// Shared types and constants of the bus cycle sequencer.
package cbseq_pkg;

    localparam logic [15:0] CBSEQ_IDLE_ADDR = 16'hFFFF;
    localparam logic [7:0] CBSEQ_PAGE_ZERO = 8'h00;
    localparam logic [15:0] CBSEQ_STEP_ONE = 16'h0001;
    localparam logic [15:0] CBSEQ_STEP_TWO = 16'h0002;
    localparam logic [2:0] CBSEQ_CYC_FIRST = 3'h1;

    // Cycle counts per instruction group.
    localparam logic [2:0] CBSEQ_LEN_IMM8 = 3'h2;
    localparam logic [2:0] CBSEQ_LEN_IMM16_LOAD = 3'h3;
    localparam logic [2:0] CBSEQ_LEN_IMM16_ALU = 3'h4;
    localparam logic [2:0] CBSEQ_LEN_DIR8 = 3'h3;
    localparam logic [2:0] CBSEQ_LEN_DIR_STORE8 = 3'h3;
    localparam logic [2:0] CBSEQ_LEN_DIR16_LOAD = 3'h4;
    localparam logic [2:0] CBSEQ_LEN_DIR16_STORE = 3'h4;
    localparam logic [2:0] CBSEQ_LEN_DIR16_ALU = 3'h5;
    localparam logic [2:0] CBSEQ_LEN_DIR_CALL = 3'h5;

    // Instruction groups that share one bus cycle sequence.
    typedef enum logic [3:0] {
        CBSEQ_IMM8,
        CBSEQ_IMM16_LOAD,
        CBSEQ_IMM16_ALU,
        CBSEQ_DIR8,
        CBSEQ_DIR_STORE8,
        CBSEQ_DIR16_LOAD,
        CBSEQ_DIR16_STORE,
        CBSEQ_DIR16_ALU,
        CBSEQ_DIR_CALL
    } cbseq_class_type;

    // What a single bus cycle does.
    typedef enum logic [3:0] {
        CBSEQ_ST_OPCODE,
        CBSEQ_ST_IMM_BYTE,
        CBSEQ_ST_IMM_HIGH,
        CBSEQ_ST_IMM_LOW,
        CBSEQ_ST_IDLE_READ,
        CBSEQ_ST_OPER_ADDR,
        CBSEQ_ST_DIR_BYTE,
        CBSEQ_ST_DIR_HIGH,
        CBSEQ_ST_DIR_LOW,
        CBSEQ_ST_WR_ACC,
        CBSEQ_ST_WR_HIGH,
        CBSEQ_ST_WR_LOW,
        CBSEQ_ST_IGNORED,
        CBSEQ_ST_SUB_FETCH,
        CBSEQ_ST_PUSH_LOW,
        CBSEQ_ST_PUSH_HIGH
    } cbseq_step_type;

    typedef struct packed {
        logic valid;
        logic rw;
        logic [15:0] addr;
        logic [7:0] wdata;
        cbseq_step_type step;
    } cbseq_bus_type;

    typedef struct packed {
        logic [15:0] opcode_addr;
        logic [15:0] sub_addr;
        logic [15:0] reg_word;
        logic [7:0] acc;
        logic [15:0] stack_ptr;
        logic [15:0] ret_addr;
    } cbseq_ctx_type;

endpackage : cbseq_pkg

// ---- hdl/cbseq_top.sv ----
// Bus cycle sequencer for immediate and direct addressing instructions.
// Notes on behaviour
// - First cycle fetches opcode; immediate byte takes two.
// - Immediate 16-bit loads read two bytes, three cycles.
// - 16-bit arithmetic appends idle read at FFFF.
// - Same group and length give identical sequences.
// - Direct 16-bit loads read high then low.
// - Direct 16-bit stores write high then low.
// - Direct call ignores byte, fetches subroutine opcode.
// - Direct call pushes return low then high.
`timescale 1ns/1ns
module cbseq_top
    import cbseq_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic START,
    input wire cbseq_class_type CLASS,
    input wire cbseq_ctx_type CTX,
    input wire logic [7:0] RD_DATA,
    output logic READY,
    output cbseq_bus_type BUS,
    output logic DONE,
    output logic [15:0] OPERAND
);

    // The sequence is a pure function of group and cycle, so every member of a group
    // necessarily produces the same bus cycles.
    function automatic cbseq_step_type step_of(cbseq_class_type cls, logic [2:0] cyc);
        cbseq_step_type s;
        s = CBSEQ_ST_OPCODE;
        if (cyc != CBSEQ_CYC_FIRST) begin
            unique case (cls)
                CBSEQ_IMM8: s = CBSEQ_ST_IMM_BYTE;
                CBSEQ_IMM16_LOAD, CBSEQ_IMM16_ALU: begin
                    s = (cyc == 3'h2) ? CBSEQ_ST_IMM_HIGH :
                        (cyc == 3'h3) ? CBSEQ_ST_IMM_LOW : CBSEQ_ST_IDLE_READ;
                end
                CBSEQ_DIR8: s = (cyc == 3'h2) ? CBSEQ_ST_OPER_ADDR : CBSEQ_ST_DIR_BYTE;
                CBSEQ_DIR_STORE8: s = (cyc == 3'h2) ? CBSEQ_ST_OPER_ADDR : CBSEQ_ST_WR_ACC;
                CBSEQ_DIR16_LOAD, CBSEQ_DIR16_ALU: begin
                    s = (cyc == 3'h2) ? CBSEQ_ST_OPER_ADDR :
                        (cyc == 3'h3) ? CBSEQ_ST_DIR_HIGH :
                        (cyc == 3'h4) ? CBSEQ_ST_DIR_LOW : CBSEQ_ST_IDLE_READ;
                end
                CBSEQ_DIR16_STORE: begin
                    s = (cyc == 3'h2) ? CBSEQ_ST_OPER_ADDR :
                        (cyc == 3'h3) ? CBSEQ_ST_WR_HIGH : CBSEQ_ST_WR_LOW;
                end
                CBSEQ_DIR_CALL: begin
                    s = (cyc == 3'h2) ? CBSEQ_ST_IGNORED :
                        (cyc == 3'h3) ? CBSEQ_ST_SUB_FETCH :
                        (cyc == 3'h4) ? CBSEQ_ST_PUSH_LOW : CBSEQ_ST_PUSH_HIGH;
                end
                default: s = CBSEQ_ST_OPCODE;
            endcase
        end
        return s;
    endfunction : step_of

    function automatic logic [2:0] len_of(cbseq_class_type cls);
        logic [2:0] n;
        n = CBSEQ_LEN_IMM8;
        unique case (cls)
            CBSEQ_IMM8: n = CBSEQ_LEN_IMM8;
            CBSEQ_IMM16_LOAD: n = CBSEQ_LEN_IMM16_LOAD;
            CBSEQ_IMM16_ALU: n = CBSEQ_LEN_IMM16_ALU;
            CBSEQ_DIR8: n = CBSEQ_LEN_DIR8;
            CBSEQ_DIR_STORE8: n = CBSEQ_LEN_DIR_STORE8;
            CBSEQ_DIR16_LOAD: n = CBSEQ_LEN_DIR16_LOAD;
            CBSEQ_DIR16_STORE: n = CBSEQ_LEN_DIR16_STORE;
            CBSEQ_DIR16_ALU: n = CBSEQ_LEN_DIR16_ALU;
            CBSEQ_DIR_CALL: n = CBSEQ_LEN_DIR_CALL;
            default: n = CBSEQ_LEN_IMM8;
        endcase
        return n;
    endfunction : len_of

    logic active;
    cbseq_class_type cls;
    logic [2:0] cyc;
    cbseq_ctx_type ctx;
    logic [15:0] oper_addr;
    logic [15:0] operand;
    logic done;
    cbseq_bus_type bus;

    logic next_active;
    cbseq_class_type next_cls;
    logic [2:0] next_cyc;
    cbseq_ctx_type next_ctx;
    logic [15:0] next_oper_addr;
    logic [15:0] next_operand;
    logic next_done;
    cbseq_bus_type next_bus;
    logic last;
    logic take;
    cbseq_step_type cur_step;
    cbseq_step_type nxt_step;

    assign last = active && (cyc == len_of(cls));
    assign READY = !active || last;
    assign take = START && READY;
    assign cur_step = step_of(cls, cyc);

    always_comb begin
        next_active = active;
        next_cls = cls;
        next_cyc = cyc;
        next_ctx = ctx;
        next_oper_addr = oper_addr;
        next_operand = operand;
        next_done = last;
        // Read data belongs to the cycle now on the bus and is captured at its end.
        if (active) begin
            unique case (cur_step)
                CBSEQ_ST_OPER_ADDR: next_oper_addr = {CBSEQ_PAGE_ZERO, RD_DATA};
                CBSEQ_ST_IMM_BYTE, CBSEQ_ST_DIR_BYTE: next_operand = {CBSEQ_PAGE_ZERO, RD_DATA};
                CBSEQ_ST_IMM_HIGH, CBSEQ_ST_DIR_HIGH: next_operand = {RD_DATA, operand[7:0]};
                CBSEQ_ST_IMM_LOW, CBSEQ_ST_DIR_LOW: next_operand = {operand[15:8], RD_DATA};
                default: next_operand = operand;
            endcase
        end
        if (take) begin
            next_active = 1'b1;
            next_cls = CLASS;
            next_cyc = CBSEQ_CYC_FIRST;
            next_ctx = CTX;
        end else if (last) begin
            next_active = 1'b0;
        end else if (active) begin
            next_cyc = cyc + 3'h1;
        end
        nxt_step = step_of(next_cls, next_cyc);
        next_bus.valid = next_active;
        next_bus.rw = 1'b1;
        next_bus.addr = CBSEQ_IDLE_ADDR;
        next_bus.wdata = 8'h00;
        next_bus.step = nxt_step;
        if (next_active) begin
            unique case (nxt_step)
                CBSEQ_ST_OPCODE: next_bus.addr = next_ctx.opcode_addr;
                CBSEQ_ST_IMM_BYTE, CBSEQ_ST_IMM_HIGH, CBSEQ_ST_OPER_ADDR, CBSEQ_ST_IGNORED: begin
                    next_bus.addr = next_ctx.opcode_addr + CBSEQ_STEP_ONE;
                end
                CBSEQ_ST_IMM_LOW: next_bus.addr = next_ctx.opcode_addr + CBSEQ_STEP_TWO;
                CBSEQ_ST_IDLE_READ: next_bus.addr = CBSEQ_IDLE_ADDR;
                CBSEQ_ST_DIR_BYTE, CBSEQ_ST_DIR_HIGH: next_bus.addr = next_oper_addr;
                CBSEQ_ST_DIR_LOW: next_bus.addr = next_oper_addr + CBSEQ_STEP_ONE;
                CBSEQ_ST_WR_ACC: begin
                    next_bus.addr = next_oper_addr;
                    next_bus.rw = 1'b0;
                    next_bus.wdata = next_ctx.acc;
                end
                CBSEQ_ST_WR_HIGH: begin
                    next_bus.addr = next_oper_addr;
                    next_bus.rw = 1'b0;
                    next_bus.wdata = next_ctx.reg_word[15:8];
                end
                CBSEQ_ST_WR_LOW: begin
                    next_bus.addr = next_oper_addr + CBSEQ_STEP_ONE;
                    next_bus.rw = 1'b0;
                    next_bus.wdata = next_ctx.reg_word[7:0];
                end
                CBSEQ_ST_SUB_FETCH: next_bus.addr = next_ctx.sub_addr;
                // The push order follows the upward stack addressing as printed.
                CBSEQ_ST_PUSH_LOW: begin
                    next_bus.addr = next_ctx.stack_ptr;
                    next_bus.rw = 1'b0;
                    next_bus.wdata = next_ctx.ret_addr[7:0];
                end
                CBSEQ_ST_PUSH_HIGH: begin
                    next_bus.addr = next_ctx.stack_ptr + CBSEQ_STEP_ONE;
                    next_bus.rw = 1'b0;
                    next_bus.wdata = next_ctx.ret_addr[15:8];
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            active <= 1'b0;
            cls <= CBSEQ_IMM8;
            cyc <= CBSEQ_CYC_FIRST;
            ctx <= '0;
            oper_addr <= 16'h0000;
            operand <= 16'h0000;
            done <= 1'b0;
            bus <= '{valid: 1'b0, rw: 1'b1, addr: CBSEQ_IDLE_ADDR, wdata: 8'h00,
                     step: CBSEQ_ST_OPCODE};
        end else begin
            active <= next_active;
            cls <= next_cls;
            cyc <= next_cyc;
            ctx <= next_ctx;
            oper_addr <= next_oper_addr;
            operand <= next_operand;
            done <= next_done;
            bus <= next_bus;
        end
    end

    assign BUS = bus;
    assign DONE = done;
    assign OPERAND = operand;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);

    a_opcode_fetch: assert property (take |=> BUS.valid && BUS.rw &&
        BUS.addr == $past(CTX.opcode_addr) && BUS.step == CBSEQ_ST_OPCODE)
        else $error("opcode fetch cycle wrong");
    a_imm8_seq: assert property (take && CLASS == CBSEQ_IMM8 |-> ##2
        (BUS.rw && BUS.addr == $past(CTX.opcode_addr, 2) + CBSEQ_STEP_ONE) ##1 DONE)
        else $error("immediate byte sequence wrong");
    a_imm16_load: assert property (take && CLASS == CBSEQ_IMM16_LOAD |-> ##3
        (BUS.rw && BUS.addr == $past(CTX.opcode_addr, 3) + CBSEQ_STEP_TWO) ##1 DONE)
        else $error("immediate word load sequence wrong");
    a_idle_read: assert property (take && CLASS == CBSEQ_IMM16_ALU |-> ##4
        (BUS.rw && BUS.addr == CBSEQ_IDLE_ADDR) ##1 DONE)
        else $error("idle read cycle missing");
    a_group_write: assert property (BUS.valid && !BUS.rw |->
        BUS.step inside {CBSEQ_ST_WR_ACC, CBSEQ_ST_WR_HIGH, CBSEQ_ST_WR_LOW,
        CBSEQ_ST_PUSH_LOW, CBSEQ_ST_PUSH_HIGH})
        else $error("write outside a write step");
    a_dir16_load: assert property (take && CLASS == CBSEQ_DIR16_LOAD |-> ##3
        (BUS.rw && BUS.addr == {CBSEQ_PAGE_ZERO, $past(RD_DATA)}) ##1
        (BUS.rw && BUS.addr == $past(BUS.addr) + CBSEQ_STEP_ONE))
        else $error("direct word load sequence wrong");
    a_dir16_store: assert property (take && CLASS == CBSEQ_DIR16_STORE |-> ##3
        (!BUS.rw && BUS.wdata == $past(CTX.reg_word[15:8], 3)) ##1
        (!BUS.rw && BUS.wdata == $past(CTX.reg_word[7:0], 4)))
        else $error("direct word store sequence wrong");
    a_call_fetch: assert property (take && CLASS == CBSEQ_DIR_CALL |-> ##2
        (BUS.rw && BUS.step == CBSEQ_ST_IGNORED) ##1
        (BUS.rw && BUS.addr == $past(CTX.sub_addr, 3)))
        else $error("call fetch sequence wrong");
    a_call_push: assert property (take && CLASS == CBSEQ_DIR_CALL |-> ##4
        (!BUS.rw && BUS.addr == $past(CTX.stack_ptr, 4)) ##1
        (!BUS.rw && BUS.wdata == $past(CTX.ret_addr[15:8], 5)))
        else $error("return address push wrong");
    a_dir8_read: assert property (take && CLASS == CBSEQ_DIR8 |-> ##3
        (BUS.rw && BUS.addr == {CBSEQ_PAGE_ZERO, $past(RD_DATA)}) ##1 DONE)
        else $error("direct byte read wrong");
    a_acc_store: assert property (take && CLASS == CBSEQ_DIR_STORE8 |-> ##3
        (!BUS.rw && BUS.wdata == $past(CTX.acc, 3)) ##1 DONE)
        else $error("accumulator store wrong");

    c_back_to_back: cover property (take ##1 !READY ##[1:5] take);
    // Every instruction lasts at least two cycles, so the cycle after a take is never the last.
    a_ready_busy: assert property (take |=> !READY)
        else $error("ready raised in first cycle");

    c_call_done: cover property (take && CLASS == CBSEQ_DIR_CALL ##6 DONE);
    c_dir_alu: cover property (take && CLASS == CBSEQ_DIR16_ALU ##6 DONE);

endmodule : cbseq_top

// ---- sim/cbseq_mem.sv ----
// Behavioural model of the program memory and data memory behind the sequencer.
`timescale 1ns/1ns
module cbseq_mem
    import cbseq_pkg::*;
(
    input wire logic CORE_CLK,
    input wire cbseq_bus_type BUS,
    output logic [7:0] RD_DATA
);
    logic [7:0] last = 8'h00;

    // Outside a read cycle nobody drives the data lines, so the model shows the inverse of the
    // last value, and a design that samples at the wrong moment cannot see stale data by luck.
    always @(posedge CORE_CLK) begin
        last <= RD_DATA;
    end

    assign RD_DATA = (BUS.valid && BUS.rw) ?
        (BUS.addr[7:0] ^ {BUS.addr[14:8], BUS.addr[15]} ^ 8'hA5) : ~last;
endmodule : cbseq_mem

// ---- sim/cbseq_top_tb.sv ----
// Self-checking testbench of the bus cycle sequencer.
`timescale 1ns/1ns
module cbseq_top_tb;
    import cbseq_pkg::*;
    logic CORE_CLK = 1'b0;
    logic SRST = 1'b1;
    logic START = 1'b0;
    cbseq_class_type CLASS = CBSEQ_IMM8;
    cbseq_ctx_type CTX = '0;
    logic [7:0] RD_DATA;
    logic READY;
    cbseq_bus_type BUS;
    logic DONE;
    logic [15:0] OPERAND;
    int error_cnt = 0;
    int num_checks = 0;
    logic [24:0] exp_bus[$];
    logic [16:0] exp_opnd[$];
    logic [24:0] e;
    logic [16:0] o;

    cbseq_top i_dut (.CORE_CLK(CORE_CLK), .SRST(SRST), .START(START), .CLASS(CLASS), .CTX(CTX),
        .RD_DATA(RD_DATA), .READY(READY), .BUS(BUS), .DONE(DONE), .OPERAND(OPERAND));
    cbseq_mem i_mem (.CORE_CLK(CORE_CLK), .BUS(BUS), .RD_DATA(RD_DATA));

    initial begin
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ {a[14:8], a[15]} ^ 8'hA5;
    endfunction : mem_byte

    task automatic compare_bus(input logic [24:0] exp, input logic [24:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED bus cycle expected %h seen %h", exp, got);
        end
    endtask : compare_bus

    task automatic compare_opnd(input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED operand expected %h seen %h", exp, got);
        end
    endtask : compare_opnd

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // Notes the whole expected bus sequence, then holds the request until it is taken.
    task automatic issue(input cbseq_class_type cls, input cbseq_ctx_type c);
        logic [15:0] p;
        logic [15:0] a;
        p = c.opcode_addr;
        a = {CBSEQ_PAGE_ZERO, mem_byte(p + 16'h0001)};
        exp_bus.push_back({p, 1'b1, 8'h00});
        exp_bus.push_back({p + 16'h0001, 1'b1, 8'h00});
        case (cls)
            CBSEQ_IMM8: exp_opnd.push_back({9'h000, mem_byte(p + 16'h0001)} | 17'h10000);
            CBSEQ_IMM16_LOAD, CBSEQ_IMM16_ALU: begin
                exp_bus.push_back({p + 16'h0002, 1'b1, 8'h00});
                exp_opnd.push_back({1'b1, mem_byte(p + 16'h0001), mem_byte(p + 16'h0002)});
            end
            CBSEQ_DIR8: begin
                exp_bus.push_back({a, 1'b1, 8'h00});
                exp_opnd.push_back({9'h100, mem_byte(a)});
            end
            CBSEQ_DIR_STORE8: begin
                exp_bus.push_back({a, 1'b0, c.acc});
                exp_opnd.push_back(17'h00000);
            end
            CBSEQ_DIR16_LOAD, CBSEQ_DIR16_ALU: begin
                exp_bus.push_back({a, 1'b1, 8'h00});
                exp_bus.push_back({a + 16'h0001, 1'b1, 8'h00});
                exp_opnd.push_back({1'b1, mem_byte(a), mem_byte(a + 16'h0001)});
            end
            CBSEQ_DIR16_STORE: begin
                exp_bus.push_back({a, 1'b0, c.reg_word[15:8]});
                exp_bus.push_back({a + 16'h0001, 1'b0, c.reg_word[7:0]});
                exp_opnd.push_back(17'h00000);
            end
            default: begin
                exp_bus.push_back({c.sub_addr, 1'b1, 8'h00});
                exp_bus.push_back({c.stack_ptr, 1'b0, c.ret_addr[7:0]});
                exp_bus.push_back({c.stack_ptr + 16'h0001, 1'b0, c.ret_addr[15:8]});
                exp_opnd.push_back(17'h00000);
            end
        endcase
        if (cls inside {CBSEQ_IMM16_ALU, CBSEQ_DIR16_ALU}) begin
            exp_bus.push_back({CBSEQ_IDLE_ADDR, 1'b1, 8'h00});
        end
        START <= 1'b1;
        CLASS <= cls;
        CTX <= c;
        do @(negedge CORE_CLK); while (READY !== 1'b1);
        @(posedge CORE_CLK);
    endtask : issue

    // Each bus cycle is judged at its closing edge; read cycles carry no write data.
    always @(posedge CORE_CLK) begin
        if (!SRST && BUS.valid) begin
            e = (exp_bus.size() > 0) ? exp_bus.pop_front() : 25'h0000000;
            compare_bus(e, {BUS.addr, BUS.rw, BUS.rw ? e[7:0] : BUS.wdata});
        end else if (!SRST) begin
            compare_bus({CBSEQ_IDLE_ADDR, 9'h100}, {BUS.addr, BUS.rw, 8'h00});
        end
        if (!SRST && DONE) begin
            o = (exp_opnd.size() > 0) ? exp_opnd.pop_front() : 17'h1FFFF;
            if (o[16]) begin
                compare_opnd(o[15:0], OPERAND);
            end
        end
    end

    initial begin
        cbseq_ctx_type c;
        int n;
        n = $urandom(32'hB27475FB);
        repeat (16) @(posedge CORE_CLK);
        SRST <= 1'b0;
        // Back to back through every group, the first pass wrapping the opcode and stack address.
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 9; k++) begin
                c = 88'({$urandom, $urandom, $urandom});
                if (r == 0) begin
                    c.opcode_addr = 16'hFFFE;
                    c.stack_ptr = 16'hFFFF;
                end
                issue(cbseq_class_type'(4'(k)), c);
            end
        end
        for (int k = 0; k < 40; k++) begin
            c = 88'({$urandom, $urandom, $urandom});
            issue(cbseq_class_type'(4'($urandom_range(8))), c);
            if ($urandom_range(1) == 1) begin
                START <= 1'b0;
                repeat (1 + $urandom_range(2)) @(posedge CORE_CLK);
            end
        end
        START <= 1'b0;
        repeat (8) @(posedge CORE_CLK);
        compare_opnd(16'h0000, 16'(exp_bus.size() + exp_opnd.size()));
        test_done();
    end

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        error_cnt++;
        test_done();
    end
endmodule : cbseq_top_tb
